// ---- hw/smbus_host_protocol_decode.sv ----
`timescale 1ns/100ps
//Contract
// - The target address goes out as one byte with the 7-bit address in bits 7..1 and direction in bit 0.
// - Protocol codes 0x02, 0x04, 0x06, 0x08, 0x0A, 0x0C and 0x0D select quick to block process call.
// - Bit 7 of the protocol code requests packet error checking for the transaction.
// - Bit 0 of the protocol code selects the read variant, clear selects write; for 0x0C and 0x0D it selects block process call.
// - Every transaction ends with a status code, zero for success and non-zero on failure.
// - The host carries an 8-bit command value, one virtual register per value.
// - Quick and send/receive byte carry no command byte and act as command value zero; the code never applies the command refusal to them.
// - The data buffer holds transfers from zero to thirty-two bytes.
// - The host runs a two-wire low-speed bus, addresses each slave and takes part in arbitration.
// - Protected accesses are refused with status 0x12 for a command or 0x17 for a whole device.
module smbus_host_protocol_decode #(
  parameter int QUARTER_CYCLES = smbus_host_pkg::QUARTER_CYCLES
) (
  // System clock and control
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  // Transaction request
  input wire logic start,
  input wire logic [7:0] protocol_select_register,
  input wire logic [7:0] target_address_register,
  input wire logic [7:0] command_value,
  input wire logic [5:0] write_length,
  // Access protection
  input wire logic deny_device_en,
  input wire logic deny_cmd_en,
  input wire logic [6:0] deny_device_addr,
  input wire logic [7:0] deny_cmd_value,
  // Data buffers
  input wire logic tx_buf_wr_en,
  input wire logic [4:0] tx_buf_wr_addr,
  input wire logic [7:0] tx_buf_wr_data,
  input wire logic [4:0] rx_buf_rd_addr,
  output logic [7:0] rx_buf_rd_data,
  // Completion
  output logic busy,
  output logic done,
  output logic [7:0] transaction_status_register,
  output logic [5:0] read_length,
  // Two-wire bus
  input wire logic link_clk,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);

  typedef struct packed {
    logic busy;
    logic done;
    logic req_tgl;
    logic done_s1;
    logic done_s2;
    logic done_seen;
    smbus_host_pkg::xfer_cfg_s cfg;
    logic [7:0] status;
    logic [5:0] rlen;
  } sys_state_s;

  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic req_seen;
    logic scl_s1;
    logic scl_s2;
    logic sda_s1;
    logic sda_s2;
    smbus_host_pkg::eng_e st;
    smbus_host_pkg::phase_e ph;
    smbus_host_pkg::plan_s plan;
    smbus_host_pkg::xfer_cfg_s cfg;
    logic [1:0] q;
    logic [15:0] div;
    logic [3:0] bcnt;
    logic [7:0] sh;
    logic nack;
    logic [5:0] idx;
    logic [5:0] rtot;
    logic [5:0] rlen;
    logic [7:0] crc;
    logic [7:0] status;
    logic done_tgl;
    logic scl_oe;
    logic sda_oe;
  } link_state_s;

  function automatic logic is_rx(input smbus_host_pkg::phase_e ph, input logic has_rd);
    return ph == smbus_host_pkg::PH_RCNT || ph == smbus_host_pkg::PH_RDATA ||
           (ph == smbus_host_pkg::PH_PEC && has_rd);
  endfunction

  sys_state_s s_q, s_d;
  link_state_s l_q, l_d;
  smbus_host_pkg::plan_s req_plan;
  logic [1:0] rst_sync_q;
  logic [1:0] ce_sync_q;
  logic link_rst_n, link_ce;
  logic [7:0] tx_rdata, tx_byte;
  logic rx_we, rx_now, rx_d, last_rx, stall, tick;
  logic [5:0] wtot;
  smbus_host_pkg::eng_e wr_next_st, rd_next_st;
  smbus_host_pkg::phase_e wr_next_ph;

  // Reset and enable brought into the link domain
  always_ff @(posedge link_clk) begin
    rst_sync_q <= {rst_sync_q[0], rst_n};
    ce_sync_q <= {ce_sync_q[0], ce};
  end
  assign link_rst_n = rst_sync_q[1];
  assign link_ce = ce_sync_q[1];

  // Software side: request, refusal, completion
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.done_s1 = l_q.done_tgl;
    s_d.done_s2 = s_q.done_s1;
    req_plan = smbus_host_pkg::decode_proto(protocol_select_register);
    if (s_q.done_s2 != s_q.done_seen) begin
      s_d.done_seen = s_q.done_s2;
      s_d.busy = 1'b0;
      s_d.done = 1'b1;
      s_d.status = l_q.status;
      s_d.rlen = l_q.rlen;
    end else if (start && !s_q.busy) begin
      s_d.done = 1'b1;
      s_d.rlen = '0;
      if (!req_plan.valid) begin
        s_d.status = smbus_host_pkg::ST_BAD_PROTO;
      end else if (req_plan.wblock && write_length > smbus_host_pkg::BUF_MAX_LEN) begin
        s_d.status = smbus_host_pkg::ST_BAD_LEN;
      end else if (deny_device_en && target_address_register[7:1] == deny_device_addr) begin
        s_d.status = smbus_host_pkg::ST_DENY_DEV;
      end else if (deny_cmd_en && req_plan.has_cmd && command_value == deny_cmd_value &&
                   target_address_register[7:1] == deny_device_addr) begin
        s_d.status = smbus_host_pkg::ST_DENY_CMD;
      end else begin
        s_d.done = 1'b0;
        s_d.busy = 1'b1;
        s_d.cfg = '{proto: protocol_select_register, addr: target_address_register,
                    cmd: command_value, wlen: write_length};
        s_d.req_tgl = !s_q.req_tgl;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // Byte presented to the bus in the current phase
  always_comb begin
    tx_byte = 8'hFF;
    unique case (l_q.ph)
      smbus_host_pkg::PH_ADDRW: tx_byte = {l_q.cfg.addr[7:1], l_q.plan.quick & l_q.cfg.proto[0]};
      smbus_host_pkg::PH_ADDRR: tx_byte = {l_q.cfg.addr[7:1], 1'b1};
      smbus_host_pkg::PH_CMD: tx_byte = l_q.cfg.cmd;
      smbus_host_pkg::PH_WCNT: tx_byte = {2'h0, l_q.cfg.wlen};
      smbus_host_pkg::PH_WDATA: tx_byte = tx_rdata;
      smbus_host_pkg::PH_PEC: tx_byte = l_q.crc;
      smbus_host_pkg::PH_RCNT, smbus_host_pkg::PH_RDATA: tx_byte = 8'hFF;
    endcase
  end

  // Link side: bit timing and byte sequencing
  always_comb begin
    l_d = l_q;
    rx_we = 1'b0;
    l_d.req_s1 = s_q.req_tgl;
    l_d.req_s2 = l_q.req_s1;
    l_d.scl_s1 = scl_i;
    l_d.scl_s2 = l_q.scl_s1;
    l_d.sda_s1 = sda_i;
    l_d.sda_s2 = l_q.sda_s1;
    rx_now = is_rx(l_q.ph, l_q.plan.has_rd);
    wtot = l_q.plan.wblock ? l_q.cfg.wlen : {4'h0, l_q.plan.wfix};
    wr_next_st = l_q.plan.has_rd ? smbus_host_pkg::E_START :
                 (l_q.plan.pec ? smbus_host_pkg::E_BYTE : smbus_host_pkg::E_STOP);
    wr_next_ph = l_q.plan.has_rd ? smbus_host_pkg::PH_ADDRR : smbus_host_pkg::PH_PEC;
    rd_next_st = l_q.plan.pec ? smbus_host_pkg::E_BYTE : smbus_host_pkg::E_STOP;
    // Slave holding the clock low stretches the high quarters
    stall = l_q.st != smbus_host_pkg::E_IDLE && (l_q.q == 2'h1 || l_q.q == 2'h2) && !l_q.scl_s2;
    tick = !stall && l_q.div == 16'(QUARTER_CYCLES - 1);
    if (l_q.st != smbus_host_pkg::E_IDLE && !stall) begin
      l_d.div = tick ? 16'h0000 : l_q.div + 16'h0001;
      if (tick) begin
        l_d.q = l_q.q + 2'h1;
      end
    end
    unique case (l_q.st)
      smbus_host_pkg::E_IDLE: begin
        if (l_q.req_s2 != l_q.req_seen) begin
          l_d.req_seen = l_q.req_s2;
          l_d.cfg = s_q.cfg;
          l_d.plan = smbus_host_pkg::decode_proto(s_q.cfg.proto);
          l_d.st = smbus_host_pkg::E_START;
          l_d.div = '0;
          l_d.q = '0;
          l_d.idx = '0;
          l_d.rlen = '0;
          l_d.crc = smbus_host_pkg::CRC_INIT;
          l_d.status = smbus_host_pkg::ST_OK;
          // Receive byte goes straight to the read address, no command byte
          l_d.ph = (l_d.plan.has_rd && !l_d.plan.has_cmd) ? smbus_host_pkg::PH_ADDRR :
                   smbus_host_pkg::PH_ADDRW;
        end
      end
      smbus_host_pkg::E_START: begin
        if (tick && l_q.q == 2'h3) begin
          l_d.st = smbus_host_pkg::E_BYTE;
          l_d.bcnt = '0;
        end
      end
      smbus_host_pkg::E_BYTE: begin
        if (l_q.div == '0 && l_q.q == '0 && l_q.bcnt == '0) begin
          l_d.sh = tx_byte;
          if (!rx_now && l_q.ph != smbus_host_pkg::PH_PEC) begin
            l_d.crc = smbus_host_pkg::crc8(l_q.crc, tx_byte);
          end
        end
        if (tick && l_q.q == 2'h2) begin
          if (l_q.bcnt == 4'h8) begin
            l_d.nack = l_q.sda_s2;
          end else if (rx_now) begin
            l_d.sh = {l_q.sh[6:0], l_q.sda_s2};
          end else if (l_q.sh[7] && !l_q.sda_s2) begin
            l_d.status = smbus_host_pkg::ST_ARB_LOST;
            l_d.st = smbus_host_pkg::E_FINISH;
          end
        end
        if (tick && l_q.q == 2'h3 && l_d.st == smbus_host_pkg::E_BYTE) begin
          if (l_q.bcnt != 4'h8) begin
            l_d.bcnt = l_q.bcnt + 4'h1;
            if (!rx_now) begin
              l_d.sh = {l_q.sh[6:0], 1'b0};
            end
          end else begin
            l_d.bcnt = '0;
            if (!rx_now && l_q.nack) begin
              l_d.status = (l_q.ph == smbus_host_pkg::PH_ADDRW || l_q.ph == smbus_host_pkg::PH_ADDRR) ?
                           smbus_host_pkg::ST_ADDR_NACK : smbus_host_pkg::ST_DATA_NACK;
              l_d.st = smbus_host_pkg::E_STOP;
            end else begin
              if (rx_now && l_q.ph != smbus_host_pkg::PH_PEC) begin
                l_d.crc = smbus_host_pkg::crc8(l_q.crc, l_q.sh);
              end
              unique case (l_q.ph)
                smbus_host_pkg::PH_ADDRW: begin
                  if (l_q.plan.quick) begin
                    l_d.st = smbus_host_pkg::E_STOP;
                  end else begin
                    l_d.ph = l_q.plan.has_cmd ? smbus_host_pkg::PH_CMD : smbus_host_pkg::PH_WDATA;
                  end
                end
                smbus_host_pkg::PH_CMD: begin
                  if (l_q.plan.wblock) begin
                    l_d.ph = smbus_host_pkg::PH_WCNT;
                  end else if (l_q.plan.wfix != 2'h0) begin
                    l_d.ph = smbus_host_pkg::PH_WDATA;
                  end else begin
                    l_d.st = wr_next_st;
                    l_d.ph = wr_next_ph;
                  end
                end
                smbus_host_pkg::PH_WCNT: begin
                  l_d.st = (l_q.cfg.wlen == '0) ? wr_next_st : smbus_host_pkg::E_BYTE;
                  l_d.ph = (l_q.cfg.wlen == '0) ? wr_next_ph : smbus_host_pkg::PH_WDATA;
                end
                smbus_host_pkg::PH_WDATA: begin
                  l_d.idx = l_q.idx + 6'h01;
                  if (l_q.idx + 6'h01 == wtot) begin
                    l_d.st = wr_next_st;
                    l_d.ph = wr_next_ph;
                  end
                end
                smbus_host_pkg::PH_ADDRR: begin
                  l_d.rtot = {4'h0, l_q.plan.rfix};
                  l_d.idx = '0;
                  l_d.ph = l_q.plan.rblock ? smbus_host_pkg::PH_RCNT : smbus_host_pkg::PH_RDATA;
                end
                smbus_host_pkg::PH_RCNT: begin
                  l_d.idx = '0;
                  if (l_q.sh > {2'h0, smbus_host_pkg::BUF_MAX_LEN}) begin
                    l_d.rtot = smbus_host_pkg::BUF_MAX_LEN;
                    l_d.status = smbus_host_pkg::ST_BAD_LEN;
                  end else begin
                    l_d.rtot = l_q.sh[5:0];
                  end
                  l_d.st = (l_q.sh == '0) ? rd_next_st : smbus_host_pkg::E_BYTE;
                  l_d.ph = (l_q.sh == '0) ? smbus_host_pkg::PH_PEC : smbus_host_pkg::PH_RDATA;
                end
                smbus_host_pkg::PH_RDATA: begin
                  rx_we = 1'b1;
                  l_d.idx = l_q.idx + 6'h01;
                  l_d.rlen = l_q.idx + 6'h01;
                  if (l_q.idx + 6'h01 == l_q.rtot) begin
                    l_d.st = rd_next_st;
                    l_d.ph = smbus_host_pkg::PH_PEC;
                  end
                end
                smbus_host_pkg::PH_PEC: begin
                  if (rx_now && l_q.sh != l_q.crc) begin
                    l_d.status = smbus_host_pkg::ST_PEC_FAIL;
                  end
                  l_d.st = smbus_host_pkg::E_STOP;
                end
              endcase
            end
          end
        end
      end
      smbus_host_pkg::E_STOP: begin
        if (tick && l_q.q == 2'h3) begin
          l_d.st = smbus_host_pkg::E_FINISH;
        end
      end
      smbus_host_pkg::E_FINISH: begin
        l_d.done_tgl = !l_q.done_tgl;
        l_d.st = smbus_host_pkg::E_IDLE;
        l_d.q = '0;
        l_d.div = '0;
      end
    endcase
    // Line drive for the next cycle; enable high pulls the wire low
    rx_d = is_rx(l_d.ph, l_d.plan.has_rd);
    last_rx = (l_d.ph == smbus_host_pkg::PH_PEC) ||
              (!l_d.plan.pec && l_d.ph == smbus_host_pkg::PH_RCNT && l_d.sh == '0) ||
              (!l_d.plan.pec && l_d.ph == smbus_host_pkg::PH_RDATA && l_d.idx + 6'h01 == l_d.rtot);
    l_d.scl_oe = ((l_d.st == smbus_host_pkg::E_START || l_d.st == smbus_host_pkg::E_BYTE) &&
                  (l_d.q == 2'h0 || l_d.q == 2'h3)) ||
                 (l_d.st == smbus_host_pkg::E_STOP && l_d.q == 2'h0);
    l_d.sda_oe = 1'b0;
    if (l_d.st == smbus_host_pkg::E_START) begin
      l_d.sda_oe = l_d.q[1];
    end else if (l_d.st == smbus_host_pkg::E_STOP) begin
      l_d.sda_oe = !l_d.q[1];
    end else if (l_d.st == smbus_host_pkg::E_BYTE) begin
      l_d.sda_oe = (l_d.bcnt == 4'h8) ? (rx_d && !last_rx) : (!rx_d && !l_d.sh[7]);
    end
  end

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      l_q <= '0;
      l_q.st <= smbus_host_pkg::E_IDLE;
      l_q.ph <= smbus_host_pkg::PH_ADDRW;
    end else if (link_ce) begin
      l_q <= l_d;
    end
  end

  // Write data from software, read data from the bus
  smbus_buffer_ram #(.WIDTH(8), .DEPTH(smbus_host_pkg::BUF_DEPTH), .AW(smbus_host_pkg::BUF_AW)) u_tx_buf (
    .wr_clk(sys_clk),
    .wr_en(tx_buf_wr_en && ce && !s_q.busy),
    .wr_addr(tx_buf_wr_addr),
    .wr_data(tx_buf_wr_data),
    .rd_clk(link_clk),
    .rd_rst_n(link_rst_n),
    .rd_en(link_ce),
    .rd_addr(l_d.idx[4:0]),
    .rd_data(tx_rdata)
  );

  smbus_buffer_ram #(.WIDTH(8), .DEPTH(smbus_host_pkg::BUF_DEPTH), .AW(smbus_host_pkg::BUF_AW)) u_rx_buf (
    .wr_clk(link_clk),
    .wr_en(rx_we && link_ce),
    .wr_addr(l_q.idx[4:0]),
    .wr_data(l_q.sh),
    .rd_clk(sys_clk),
    .rd_rst_n(rst_n),
    .rd_en(ce),
    .rd_addr(rx_buf_rd_addr),
    .rd_data(rx_buf_rd_data)
  );

  assign busy = s_q.busy;
  assign done = s_q.done;
  assign transaction_status_register = s_q.status;
  assign read_length = s_q.rlen;
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = l_q.scl_oe;
  assign sda_oe = l_q.sda_oe;

endmodule

// ---- pkg/smbus_host_pkg.sv ----
package smbus_host_pkg;

  // Buffer geometry
  localparam int BUF_DEPTH = 32;
  localparam int BUF_AW = 5;
  localparam int LEN_W = 6;
  localparam logic [5:0] BUF_MAX_LEN = 6'h20;

  // Protocol field positions and base codes
  localparam int PEC_BIT = 7;
  localparam int RW_BIT = 0;
  localparam logic [7:0] PROTO_QUICK = 8'h02;
  localparam logic [7:0] PROTO_SEND_RECV = 8'h04;
  localparam logic [7:0] PROTO_BYTE = 8'h06;
  localparam logic [7:0] PROTO_WORD = 8'h08;
  localparam logic [7:0] PROTO_BLOCK = 8'h0A;
  localparam logic [7:0] PROTO_PROC_CALL = 8'h0C;
  localparam logic [7:0] PROTO_BLOCK_PROC = 8'h0D;

  // Completion status codes
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_ADDR_NACK = 8'h10;
  localparam logic [7:0] ST_DATA_NACK = 8'h11;
  localparam logic [7:0] ST_DENY_CMD = 8'h12;
  localparam logic [7:0] ST_BAD_LEN = 8'h13;
  localparam logic [7:0] ST_DENY_DEV = 8'h17;
  localparam logic [7:0] ST_ARB_LOST = 8'h18;
  localparam logic [7:0] ST_BAD_PROTO = 8'h19;
  localparam logic [7:0] ST_PEC_FAIL = 8'h1A;

  // Packet error check polynomial x^8+x^2+x+1
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;

  // Bus timing: quarter of a 100 kHz bit on a 6 ns link clock
  localparam int LINK_PERIOD_PS = 6000;
  localparam int QUARTER_BIT_PS = 2500000;
  localparam int QUARTER_CYCLES = QUARTER_BIT_PS / LINK_PERIOD_PS;

  typedef enum logic [4:0] {
    E_IDLE = 5'h01,
    E_START = 5'h02,
    E_BYTE = 5'h04,
    E_STOP = 5'h08,
    E_FINISH = 5'h10
  } eng_e;

  typedef enum logic [7:0] {
    PH_ADDRW = 8'h01,
    PH_CMD = 8'h02,
    PH_WCNT = 8'h04,
    PH_WDATA = 8'h08,
    PH_ADDRR = 8'h10,
    PH_RCNT = 8'h20,
    PH_RDATA = 8'h40,
    PH_PEC = 8'h80
  } phase_e;

  typedef struct packed {
    logic valid;
    logic pec;
    logic quick;
    logic has_cmd;
    logic [1:0] wfix;
    logic wblock;
    logic has_rd;
    logic [1:0] rfix;
    logic rblock;
  } plan_s;

  typedef struct packed {
    logic [7:0] proto;
    logic [7:0] addr;
    logic [7:0] cmd;
    logic [5:0] wlen;
  } xfer_cfg_s;

  // Protocol code to transaction shape
  function automatic plan_s decode_proto(input logic [7:0] p);
    plan_s r;
    logic rd;
    r = '0;
    rd = p[RW_BIT];
    r.valid = 1'b1;
    r.pec = p[PEC_BIT];
    case ({1'b0, p[6:1], 1'b0})
      PROTO_QUICK: r.quick = 1'b1;
      PROTO_SEND_RECV: begin
        r.has_rd = rd;
        r.rfix = rd ? 2'h1 : 2'h0;
        r.wfix = rd ? 2'h0 : 2'h1;
      end
      PROTO_BYTE, PROTO_WORD: begin
        r.has_cmd = 1'b1;
        r.has_rd = rd;
        r.rfix = rd ? p[3:2] : 2'h0;
        r.wfix = rd ? 2'h0 : p[3:2];
      end
      PROTO_BLOCK: begin
        r.has_cmd = 1'b1;
        r.has_rd = rd;
        r.rblock = rd;
        r.wblock = !rd;
      end
      PROTO_PROC_CALL: begin
        r.has_cmd = 1'b1;
        r.has_rd = 1'b1;
        r.wblock = (p[6:0] == PROTO_BLOCK_PROC[6:0]);
        r.rblock = (p[6:0] == PROTO_BLOCK_PROC[6:0]);
        r.wfix = r.wblock ? 2'h0 : 2'h2;
        r.rfix = r.rblock ? 2'h0 : 2'h2;
      end
      default: r.valid = 1'b0;
    endcase
    return r;
  endfunction

  // One byte through the packet error check
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ({r[6:0], 1'b0} ^ CRC_POLY) : {r[6:0], 1'b0};
    end
    return r;
  endfunction

endpackage

// ---- hw/smbus_buffer_ram.sv ----
`timescale 1ns/100ps
module smbus_buffer_ram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  // Write port
  input wire logic wr_clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Read port
  input wire logic rd_clk,
  input wire logic rd_rst_n,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge wr_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge rd_clk) begin
    if (!rd_rst_n) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

// ---- test/smbus_host_protocol_decode_properties.sv ----
`timescale 1ns/100ps
module smbus_host_protocol_decode_properties (
  // Request side
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic start,
  input wire logic [7:0] protocol_select_register,
  input wire logic [7:0] target_address_register,
  input wire logic [7:0] command_value,
  input wire logic [5:0] write_length,
  input wire logic deny_device_en,
  input wire logic deny_cmd_en,
  input wire logic [6:0] deny_device_addr,
  input wire logic [7:0] deny_cmd_value,
  // Results
  input wire logic busy,
  input wire logic done,
  input wire logic [7:0] transaction_status_register,
  input wire logic [5:0] read_length,
  input wire logic scl_oe,
  input wire logic sda_oe
);
  logic [7:0] base;
  logic take, bad, blk, am, nod, ok_len;
  assign base = {1'b0, protocol_select_register[6:1], 1'b0};
  assign take = start && ce && !busy;
  assign bad = !(base inside {8'h02, 8'h04, 8'h06, 8'h08, 8'h0A, 8'h0C});
  assign blk = (base == 8'h0A && !protocol_select_register[0]) || protocol_select_register[6:0] == 7'h0D;
  assign am = target_address_register[7:1] == deny_device_addr;
  assign nod = !deny_device_en && !deny_cmd_en;
  assign ok_len = !(blk && write_length > 6'h20);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_reserved; take && bad && nod |=> done && !busy && transaction_status_register == 8'h19; endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code not refused");
  property p_deny_dev; take && !bad && ok_len && deny_device_en && am |=> done && transaction_status_register == 8'h17;
  endproperty
  a_deny_dev: assert property (p_deny_dev) else $error("device deny missing");
  property p_deny_cmd; take && !bad && ok_len && !deny_device_en && deny_cmd_en && am && base > 8'h04
    && command_value == deny_cmd_value |=> done && transaction_status_register == 8'h12; endproperty
  a_deny_cmd: assert property (p_deny_cmd) else $error("command deny missing");
  property p_bad_len; take && blk && !ok_len && nod |=> done && transaction_status_register == 8'h13; endproperty
  a_bad_len: assert property (p_bad_len) else $error("long block not refused");
  property p_end; $fell(busy) |-> done; endproperty
  a_end: assert property (p_end) else $error("busy fell without done");
  property p_hold; !done ##1 !done |-> $stable(transaction_status_register); endproperty
  a_hold: assert property (p_hold) else $error("status moved without done");
  property p_take; take |=> busy != done; endproperty
  a_take: assert property (p_take) else $error("start neither run nor refused");
  property p_idle; !busy |-> !scl_oe && !sda_oe; endproperty
  a_idle: assert property (p_idle) else $error("bus driven while idle");
  property p_len; done |-> read_length <= 6'h20; endproperty
  a_len: assert property (p_len) else $error("read length above limit");
  c_ok: cover property (done && transaction_status_register == 8'h00 && read_length == 6'h02);
  c_deny: cover property (done && transaction_status_register == 8'h12);
  c_bus: cover property (busy && sda_oe);
endmodule
bind smbus_host_protocol_decode smbus_host_protocol_decode_properties u_props (.*);

// ---- test/smbus_slave_model.sv ----
`timescale 1ns/100ps
module smbus_slave_model #(
  parameter logic [6:0] ADDR = 7'h0B
) (
  // Wires and stall control
  input wire logic scl,
  input wire logic sda,
  input wire logic slow,
  output logic scl_oe,
  output logic sda_oe
);
  logic [7:0] sh, tx, n, rn;
  logic [7:0] rx_q [0:63];
  logic smp, first, act, rdp, rd;
  int bits;
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    n = 8'h00;
    act = 1'b0;
  end
  // Start or repeated start
  always @(negedge sda) if (scl) begin
    bits = -1;
    first = 1'b1;
    rd = 1'b0;
    rdp = 1'b0;
  end
  always @(posedge scl) smp = sda;
  always @(negedge scl) begin
    if (bits < 8) begin
      sh = {sh[6:0], smp};
      bits++;
    end else bits = 0;
    sda_oe = 1'b0;
    if (bits == 8 && !rd) begin
      rx_q[n] = sh;
      n++;
      if (first) begin
        act = sh[7:1] == ADDR;
        rdp = act && sh[0];
        rn = 8'h00;
      end
      first = 1'b0;
      sda_oe = act;
    end else if (bits == 0 && (rdp || (rd && !smp))) begin
      rd = 1'b1;
      rdp = 1'b0;
      tx = (rn == 8'h00) ? 8'h02 : 8'hC0 + rn;
      rn++;
    end else if (bits == 0) rd = 1'b0;
    if (rd && bits < 8) sda_oe = !tx[7 - bits];
    if (slow) begin
      scl_oe = 1'b1;
      #100 scl_oe = 1'b0;
    end
  end
endmodule

// ---- test/tb.sv ----
`timescale 1ns/100ps
module tb;
  logic sys_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  logic [7:0] proto = 8'h00;
  logic [7:0] taddr = 8'h16;
  logic [7:0] cmd = 8'h00;
  logic [5:0] wlen = 6'h00;
  logic dev_en = 1'b0;
  logic cmd_en = 1'b0;
  logic [6:0] daddr = 7'h0B;
  logic [7:0] dcmd = 8'h5A;
  logic wr_en = 1'b0;
  logic [4:0] wr_addr = 5'h00;
  logic [7:0] wr_data = 8'h00;
  logic [4:0] rd_addr = 5'h00;
  logic slow = 1'b0;
  logic [7:0] rd_data, status;
  logic [5:0] rlen;
  logic busy, done, s_scl, s_sda, scl_oe, sda_oe, scl, sda;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  always #2.5 sys_clk = !sys_clk;
  always #3 link_clk = !link_clk;
  assign scl = !(scl_oe || s_scl);
  assign sda = !(sda_oe || s_sda);
  smbus_host_protocol_decode #(.QUARTER_CYCLES(4)) DUT (.sys_clk(sys_clk), .rst_n(rst_n), .ce(1'b1),
    .start(start), .protocol_select_register(proto), .target_address_register(taddr), .command_value(cmd),
    .write_length(wlen), .deny_device_en(dev_en), .deny_cmd_en(cmd_en), .deny_device_addr(daddr),
    .deny_cmd_value(dcmd), .tx_buf_wr_en(wr_en), .tx_buf_wr_addr(wr_addr), .tx_buf_wr_data(wr_data),
    .rx_buf_rd_addr(rd_addr), .rx_buf_rd_data(rd_data), .busy(busy), .done(done),
    .transaction_status_register(status), .read_length(rlen), .link_clk(link_clk), .scl_i(scl),
    .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe));
  smbus_slave_model S (.scl(scl), .sda(sda), .slow(slow), .scl_oe(s_scl), .sda_oe(s_sda));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic go(input logic [7:0] p, input logic [7:0] c, input logic [5:0] wl);
    int k;
    proto = p;
    cmd = c;
    wlen = wl;
    start = 1'b1;
    S.n = 8'h00;
    @(negedge sys_clk);
    start = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 20000) begin
      @(negedge sys_clk);
      k++;
    end
    if (k == 20000) chk(8'h00, 8'h01);
  endtask
  task automatic fill(input int cnt);
    for (int i = 0; i < cnt; i++) begin
      wr_en = 1'b1;
      wr_addr = i[4:0];
      wr_data = 8'hA0 + i[7:0];
      @(negedge sys_clk);
    end
    wr_en = 1'b0;
  endtask
  task automatic t_refuse;
    logic [7:0] codes [4] = '{8'h00, 8'h0E, 8'h10, 8'hFE};
    for (int i = 0; i < 4; i++) begin
      go(codes[i], 8'h00, 6'h00);
      chk(status, 8'h19);
      chk({7'h00, busy}, 8'h00);
    end
    dev_en = 1'b1;
    cmd_en = 1'b1;
    go(8'h08, 8'h5A, 6'h00);
    chk(status, 8'h17);
    dev_en = 1'b0;
    go(8'h06, 8'h5A, 6'h00);
    chk(status, 8'h12);
    cmd_en = 1'b0;
    go(8'h0A, 8'h00, 6'h21);
    chk(status, 8'h13);
    $display("t_refuse finished");
  endtask
  task automatic t_codes;
    logic [7:0] pc [7] = '{8'h02, 8'h04, 8'h06, 8'h08, 8'h0A, 8'h0C, 8'h0D};
    logic [7:0] nb [7] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h05, 8'h06};
    logic [7:0] lb [7] = '{8'h16, 8'hA0, 8'hA0, 8'hA1, 8'hA1, 8'h17, 8'h17};
    fill(2);
    for (int i = 0; i < 7; i++) begin
      slow = i[0];
      go(pc[i], 8'h33, 6'h02);
      chk(status, 8'h00);
      chk(S.n, nb[i]);
      chk(S.rx_q[0], 8'h16);
      chk(S.rx_q[S.n - 8'h01], lb[i]);
      if (i > 1) chk(S.rx_q[1], 8'h33);
    end
    slow = 1'b0;
    $display("t_codes finished");
  endtask
  task automatic t_read_pec;
    go(8'h09, 8'h21, 6'h00);
    chk(status, 8'h00);
    chk(S.rx_q[2], 8'h17);
    chk({2'h0, rlen}, 8'h02);
    rd_addr = 5'h01;
    @(negedge sys_clk);
    chk(rd_data, 8'hC1);
    go(8'h88, 8'h33, 6'h00);
    chk(S.n, 8'h05);
    chk(S.rx_q[4], 8'h39);
    go(8'h87, 8'h33, 6'h00);
    chk(status, 8'h1A);
    go(8'h0B, 8'h33, 6'h00);
    chk(status, 8'h00);
    chk({2'h0, rlen}, 8'h02);
    go(8'h05, 8'h00, 6'h00);
    chk(S.n, 8'h01);
    chk(S.rx_q[0], 8'h17);
    taddr = 8'h20;
    go(8'h06, 8'h33, 6'h00);
    chk(status, 8'h10);
    taddr = 8'h16;
    fill(32);
    go(8'h0A, 8'h40, 6'h20);
    chk(status, 8'h00);
    chk(S.rx_q[34], 8'hBF);
    $display("t_read_pec finished");
  endtask
  task automatic close_out;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    t_refuse();
    t_codes();
    t_read_pec();
    close_out();
  end
endmodule
